// File: core/ursr_cfg.svh
// Purpose: Constants for the receiver status block: offsets, fields, resets, counts
// Assumes: Included by its bare name from every core module file
// Notes:   Offsets are word indices; byte address is four times the index
`ifndef URSR_CFG_SVH
`define URSR_CFG_SVH
`define URSR_IDX_SCR   8'h13
`define URSR_IDX_CFG   8'h14
`define URSR_IDX_RSR   8'h15
`define URSR_IDX_DATA  8'h17
`define URSR_B_BF      7
`define URSR_B_OE      6
`define URSR_B_PE      5
`define URSR_B_FE      4
`define URSR_B_FS      3
`define URSR_B_MC      2
`define URSR_B_SS      1
`define URSR_B_RE      0
`define URSR_CFG_W     5
`define URSR_RSR_RST   8'h00
`define URSR_CFG_RST   5'h01
`define URSR_SCR_RST   8'h00
`define URSR_WLEN      4'h8
`define URSR_STABLE    2'h3
`define URSR_CHK_ON    4'h4
`define URSR_SAMPLE    4'h8
`define URSR_MARK      1'b1
`endif

// File: core/ursr_pkg.sv
// Purpose: Types shared by the receiver status block
// Assumes: Constants come from ursr_cfg.svh
// Notes:   Configuration bit 0 is the format select
package ursr_pkg;
	typedef enum logic [2:0] {
		ursr_st_idle = 3'h0,
		ursr_st_data = 3'h1,
		ursr_st_par  = 3'h3,
		ursr_st_stop = 3'h2,
		ursr_st_brk  = 3'h6
	} ursr_state_t;
	typedef struct packed {
		logic err_en;
		logic par_even;
		logic par_en;
		logic div16;
		logic async_fmt;
	} ursr_cfg_t;
	typedef struct packed {
		logic [7:0] data;
		logic       par_bad;
		logic       frm_bad;
		logic       match;
	} ursr_word_t;
	typedef struct packed {
		logic stb;
		logic val;
	} ursr_bit_t;
endpackage

// File: core/ursr_line_filter.sv
// Purpose: Accept a receive line change only after it is stable on the receive clock
// Assumes: tick_i marks one rising receive clock edge, one cycle wide
// Notes:   Edge outputs are combinational and valid on the tick that accepts them
`timescale 1ns/100ps
`default_nettype none
`include "ursr_cfg.svh"
module ursr_line_filter (
	input  wire logic ref_clk_i,
	input  wire logic rst_n_i,
	input  wire logic ce_i,
	input  wire logic clr_i,
	input  wire logic tick_i,
	input  wire logic line_i,
	output logic      level_o,
	output logic      rise_o,
	output logic      fall_o
);
	logic [1:0] cnt_q;
	logic       take_w;

	// Third differing sample in a row makes a valid transition
	assign take_w = tick_i & (line_i != level_o) & (cnt_q == (`URSR_STABLE - 2'h1));
	assign rise_o = take_w & line_i;
	assign fall_o = take_w & ~line_i;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			level_o <= `URSR_MARK;
			cnt_q   <= 2'h0;
		end else if (ce_i) begin
			if (clr_i) begin
				level_o <= `URSR_MARK;
				cnt_q   <= 2'h0;
			end else if (take_w) begin
				level_o <= line_i;
				cnt_q   <= 2'h0;
			end else if (tick_i) begin
				cnt_q <= (line_i == level_o) ? 2'h0 : cnt_q + 2'h1;
			end
		end
	end
endmodule
`default_nettype wire

// File: core/ursr_bit_timer.sv
// Purpose: Bit sampling strobe, with start check and resync in divide-by-16 mode
// Assumes: Edge inputs come from the line filter on the same tick
// Notes:   In divide-by-1 mode the raw line is sampled on every tick
`timescale 1ns/100ps
`default_nettype none
`include "ursr_cfg.svh"
module ursr_bit_timer (
	input  wire logic   ref_clk_i,
	input  wire logic   rst_n_i,
	input  wire logic   ce_i,
	input  wire logic   clr_i,
	input  wire logic   tick_i,
	input  wire logic   line_i,
	input  wire logic   div16_i,
	input  wire logic   async_i,
	input  wire logic   hunt_i,
	input  wire logic   level_i,
	input  wire logic   rise_i,
	input  wire logic   fall_i,
	output ursr_pkg::ursr_bit_t bit_o
);
	logic [3:0] ph_q;
	logic       chk_q;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			ph_q  <= 4'h0;
			chk_q <= 1'b0;
			bit_o <= '0;
		end else if (ce_i) begin
			bit_o.stb <= 1'b0;
			if (clr_i) begin
				ph_q  <= 4'h0;
				chk_q <= 1'b0;
			end else if (tick_i && !div16_i) begin
				bit_o.stb <= 1'b1;
				bit_o.val <= line_i;
			end else if (tick_i) begin
				if (async_i && hunt_i && !chk_q) begin
					// Waiting for a valid falling edge to open the start check
					chk_q <= fall_i;
					ph_q  <= 4'h0;
				end else if (chk_q && rise_i) begin
					chk_q <= 1'b0;
				end else if ((rise_i || fall_i) && !chk_q && ph_q >= `URSR_CHK_ON) begin
					ph_q <= 4'h0;
				end else begin
					ph_q <= ph_q + 4'h1;
					if (ph_q == `URSR_SAMPLE) begin
						// Filtered level, not raw line, so a glitch cannot be sampled
						bit_o.stb <= 1'b1;
						bit_o.val <= level_i;
						chk_q     <= 1'b0;
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

// File: core/ursr_receiver.sv
// Purpose: Receive side of a serial port with latched status flags and APB registers
// Assumes: Receive clock and line are synchronous inputs; word length is eight bits
// Notes:   Zero wait state APB slave while ce_i is high
`timescale 1ns/100ps
`default_nettype none
`include "ursr_cfg.svh"
// Overview of operation
// - Buffer full set on load, cleared by data read
// - Overrun keeps old buffered word
// - Overrun shows only after buffer read
// - Status read clears overrun; loads blocked until then
// - Parity flag follows each loaded word
// - Framing flag on load, asynchronous only
// - Cleared found bit starts sync search
// - Sync match sets found, error interrupt, no load
// - Break flag on zero word, held, suppressed when full
// - Match flag follows loaded word in sync
// - Character in progress in asynchronous format
// - Sync strip discards sync words
// - Enable bit zero stops receiver, clears flags
// - Two requests, one per word
// - Error channel covers error events
// - Flags frozen until word read
// - Break during full buffer shows after read
// - Break with overrun set sets break
// - Break interrupts at start and end
// - Asynchronous waits for zero start bit
// - Three-edge filter, eight-edge start check
// - Transition at phase four or later resets phase; sample at eight
// - Resync only in divide-by-16
// - Data read gives buffer; write goes transmitter
module ursr_receiver (
	input  wire logic        ref_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        ce_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [9:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        rx_clk_i,
	input  wire logic        rx_data_i,
	output logic             irq_full_o,
	output logic             irq_err_o,
	output logic      [7:0]  tx_wdata_o,
	output logic             tx_wstb_o
);
	ursr_pkg::ursr_cfg_t   cfg_q;
	ursr_pkg::ursr_state_t st_q;
	ursr_pkg::ursr_word_t  wd_q;
	ursr_pkg::ursr_bit_t   bit_w;
	logic [7:0]  scr_q, buf_q, sh_q, shin_w, rsr_w;
	logic [3:0]  bcnt_q;
	logic [31:0] rd_mux;
	logic sel_rsr, sel_dat, sel_scr, sel_cfg, mapped, acc_w, lat_q;
	logic wr_rsr_w, rd_rsr_w, rd_dat_w, wr_dat_w, rx_off;
	logic re_q, ss_q, fs_q, bf_q, pe_q, fe_q, mt_q, oe_q, ovp_q;
	logic brk_q, bon_q, bpend_q, back_q, endp_q;
	logic rxc_q, tick_w, level_w, rise_w, fall_w, hunt_w, cip_w, pbad_q, pbad_w;
	logic wd_vld_q, brk_det_q, brk_end_q, found_q;
	logic strip_w, load_w, ovr_w, imm_w, late_w, end_irq_w, ld_err_w, err_evt, full_evt;
	logic [7:0]  rsr_rst_w;

	assign rsr_rst_w = `URSR_RSR_RST;

	// Register decode, byte address is four times the index
	assign sel_rsr   = paddr_i[9:2] == `URSR_IDX_RSR;
	assign sel_dat   = paddr_i[9:2] == `URSR_IDX_DATA;
	assign sel_scr   = paddr_i[9:2] == `URSR_IDX_SCR;
	assign sel_cfg   = paddr_i[9:2] == `URSR_IDX_CFG;
	assign mapped    = sel_rsr | sel_dat | sel_scr | sel_cfg;
	assign acc_w     = psel_i & penable_i & ce_i & lat_q;
	assign pready_o  = acc_w;
	assign pslverr_o = acc_w & ~mapped;
	assign wr_rsr_w  = acc_w & pwrite_i & sel_rsr;
	assign rd_rsr_w  = acc_w & ~pwrite_i & sel_rsr;
	assign rd_dat_w  = acc_w & ~pwrite_i & sel_dat;
	assign wr_dat_w  = acc_w & pwrite_i & sel_dat;
	assign rx_off    = ~re_q | (wr_rsr_w & ~pwdata_i[`URSR_B_RE]);

	assign cip_w = cfg_q.async_fmt & (st_q == ursr_pkg::ursr_st_data ||
		st_q == ursr_pkg::ursr_st_par || st_q == ursr_pkg::ursr_st_stop);
	assign rsr_w = {bf_q, oe_q, pe_q, fe_q, cfg_q.async_fmt ? brk_q : fs_q,
		cfg_q.async_fmt ? cip_w : mt_q, ss_q, re_q};

	always_comb begin
		rd_mux = 32'h0;
		if (sel_rsr) begin
			rd_mux = {24'h0, rsr_w};
		end else if (sel_dat) begin
			rd_mux = {24'h0, buf_q};
		end else if (sel_scr) begin
			rd_mux = {24'h0, scr_q};
		end else if (sel_cfg) begin
			rd_mux = {27'h0, cfg_q};
		end
	end

	// Read data caught in the setup cycle so it comes from a flip-flop
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			prdata_o <= 32'h0;
			lat_q    <= 1'b0;
		end else if (ce_i) begin
			if (acc_w) begin
				lat_q <= 1'b0;
			end else if (psel_i) begin
				lat_q    <= 1'b1;
				prdata_o <= rd_mux;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			tx_wdata_o <= 8'h0;
			tx_wstb_o  <= 1'b0;
		end else if (ce_i) begin
			tx_wstb_o <= wr_dat_w;
			if (wr_dat_w) begin
				tx_wdata_o <= pwdata_i[7:0];
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			re_q  <= rsr_rst_w[`URSR_B_RE];
			ss_q  <= 1'b0;
			fs_q  <= 1'b0;
			cfg_q <= `URSR_CFG_RST;
			scr_q <= `URSR_SCR_RST;
		end else if (ce_i) begin
			if (wr_rsr_w) begin
				re_q <= pwdata_i[`URSR_B_RE];
				ss_q <= pwdata_i[`URSR_B_SS];
			end
			if (rx_off) begin
				fs_q <= 1'b0;
			end else if (found_q) begin
				fs_q <= 1'b1;
			end else if (wr_rsr_w && !cfg_q.async_fmt) begin
				fs_q <= pwdata_i[`URSR_B_FS];
			end
			if (acc_w && pwrite_i && sel_cfg) begin
				cfg_q <= ursr_pkg::ursr_cfg_t'(pwdata_i[`URSR_CFG_W-1:0]);
			end
			if (acc_w && pwrite_i && sel_scr) begin
				scr_q <= pwdata_i[7:0];
			end
		end
	end

	// Receive clock is sampled; its rising edge becomes a one-cycle tick
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			rxc_q <= 1'b0;
		end else if (ce_i) begin
			rxc_q <= rx_clk_i;
		end
	end
	assign tick_w = ce_i & rx_clk_i & ~rxc_q;
	assign hunt_w = cfg_q.async_fmt & (st_q == ursr_pkg::ursr_st_idle);

	ursr_line_filter u_filter (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.ce_i      (ce_i),
		.clr_i     (rx_off),
		.tick_i    (tick_w),
		.line_i    (rx_data_i),
		.level_o   (level_w),
		.rise_o    (rise_w),
		.fall_o    (fall_w)
	);

	ursr_bit_timer u_timer (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.ce_i      (ce_i),
		.clr_i     (rx_off),
		.tick_i    (tick_w),
		.line_i    (rx_data_i),
		.div16_i   (cfg_q.div16),
		.async_i   (cfg_q.async_fmt),
		.hunt_i    (hunt_w),
		.level_i   (level_w),
		.rise_i    (rise_w),
		.fall_i    (fall_w),
		.bit_o     (bit_w)
	);

	assign shin_w = {bit_w.val, sh_q[7:1]};
	assign pbad_w = cfg_q.par_en & ((^{sh_q, bit_w.val}) ^ ~cfg_q.par_even);

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			st_q      <= ursr_pkg::ursr_st_idle;
			sh_q      <= 8'h0;
			bcnt_q    <= 4'h0;
			pbad_q    <= 1'b0;
			wd_q      <= '0;
			wd_vld_q  <= 1'b0;
			brk_det_q <= 1'b0;
			brk_end_q <= 1'b0;
			found_q   <= 1'b0;
		end else if (ce_i) begin
			wd_vld_q  <= 1'b0;
			brk_det_q <= 1'b0;
			brk_end_q <= 1'b0;
			found_q   <= 1'b0;
			if (rx_off) begin
				st_q   <= ursr_pkg::ursr_st_idle;
				bcnt_q <= 4'h0;
			end else if (!cfg_q.async_fmt && !fs_q && st_q != ursr_pkg::ursr_st_idle) begin
				st_q <= ursr_pkg::ursr_st_idle;
			end else if (bit_w.stb) begin
				case (st_q)
				ursr_pkg::ursr_st_idle: begin
					if (cfg_q.async_fmt) begin
						if (!bit_w.val) begin
							st_q   <= ursr_pkg::ursr_st_data;
							bcnt_q <= 4'h0;
						end
					end else if (!fs_q) begin
						// Search: word counter idle, compare every bit
						sh_q <= shin_w;
						if (shin_w == scr_q) begin
							found_q <= 1'b1;
							st_q    <= ursr_pkg::ursr_st_data;
							bcnt_q  <= 4'h0;
						end
					end else begin
						sh_q   <= shin_w;
						st_q   <= ursr_pkg::ursr_st_data;
						bcnt_q <= 4'h1;
					end
				end
				ursr_pkg::ursr_st_data: begin
					sh_q   <= shin_w;
					bcnt_q <= bcnt_q + 4'h1;
					if (bcnt_q == `URSR_WLEN - 4'h1) begin
						pbad_q <= 1'b0;
						bcnt_q <= 4'h0;
						if (cfg_q.par_en) begin
							st_q <= ursr_pkg::ursr_st_par;
						end else if (cfg_q.async_fmt) begin
							st_q <= ursr_pkg::ursr_st_stop;
						end else begin
							wd_q     <= '{shin_w, 1'b0, 1'b0, shin_w == scr_q};
							wd_vld_q <= 1'b1;
						end
					end
				end
				ursr_pkg::ursr_st_par: begin
					pbad_q <= pbad_w;
					if (cfg_q.async_fmt) begin
						st_q <= ursr_pkg::ursr_st_stop;
					end else begin
						st_q     <= ursr_pkg::ursr_st_data;
						wd_q     <= '{sh_q, pbad_w, 1'b0, sh_q == scr_q};
						wd_vld_q <= 1'b1;
					end
				end
				ursr_pkg::ursr_st_stop: begin
					if (!bit_w.val && sh_q == 8'h0) begin
						st_q      <= ursr_pkg::ursr_st_brk;
						brk_det_q <= 1'b1;
					end else begin
						st_q     <= ursr_pkg::ursr_st_idle;
						wd_q     <= '{sh_q, pbad_q, ~bit_w.val, sh_q == scr_q};
						wd_vld_q <= 1'b1;
					end
				end
				ursr_pkg::ursr_st_brk: begin
					if (bit_w.val) begin
						st_q      <= ursr_pkg::ursr_st_idle;
						brk_end_q <= 1'b1;
					end
				end
				default: begin
					st_q <= ursr_pkg::ursr_st_idle;
				end
				endcase
			end
		end
	end

	assign strip_w = wd_vld_q & ss_q & ~cfg_q.async_fmt & wd_q.match;
	assign load_w  = wd_vld_q & ~strip_w & ~bf_q & ~oe_q & ~rx_off;
	assign ovr_w   = wd_vld_q & ~strip_w & (bf_q | oe_q) & ~rx_off;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			buf_q <= 8'h0;
			bf_q  <= 1'b0;
			pe_q  <= 1'b0;
			fe_q  <= 1'b0;
			mt_q  <= 1'b0;
		end else if (ce_i) begin
			if (rx_off) begin
				bf_q <= 1'b0;
				pe_q <= 1'b0;
				fe_q <= 1'b0;
				mt_q <= 1'b0;
			end else if (load_w) begin
				// Flags load only here, so they stay tied to the buffered word
				buf_q <= wd_q.data;
				bf_q  <= 1'b1;
				pe_q  <= wd_q.par_bad;
				fe_q  <= cfg_q.async_fmt & wd_q.frm_bad;
				mt_q  <= ~cfg_q.async_fmt & wd_q.match;
			end else if (rd_dat_w) begin
				bf_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			ovp_q <= 1'b0;
			oe_q  <= 1'b0;
		end else if (ce_i) begin
			if (rx_off) begin
				ovp_q <= 1'b0;
				oe_q  <= 1'b0;
			end else begin
				if (ovr_w) begin
					ovp_q <= 1'b1;
				end else if (rd_dat_w) begin
					ovp_q <= 1'b0;
				end
				if (rd_dat_w && ovp_q) begin
					oe_q <= 1'b1;
				end else if (rd_rsr_w) begin
					oe_q <= 1'b0;
				end
			end
		end
	end

	assign imm_w     = brk_det_q & (~bf_q | oe_q);
	assign late_w    = rd_dat_w & bpend_q;
	assign end_irq_w = (brk_end_q & brk_q & back_q) | (rd_rsr_w & endp_q);

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			brk_q   <= 1'b0;
			bon_q   <= 1'b0;
			bpend_q <= 1'b0;
			back_q  <= 1'b0;
			endp_q  <= 1'b0;
		end else if (ce_i) begin
			if (rx_off) begin
				brk_q   <= 1'b0;
				bon_q   <= 1'b0;
				bpend_q <= 1'b0;
				back_q  <= 1'b0;
				endp_q  <= 1'b0;
			end else begin
				if (brk_det_q) begin
					bon_q <= 1'b1;
				end else if (brk_end_q) begin
					bon_q <= 1'b0;
				end
				if (brk_det_q && !imm_w) begin
					bpend_q <= 1'b1;
				end else if (rd_dat_w) begin
					bpend_q <= 1'b0;
				end
				// A new break wins over a clear in the same cycle
				if (imm_w || late_w) begin
					brk_q  <= 1'b1;
					back_q <= 1'b0;
				end else if (brk_q && !bon_q && (back_q || rd_rsr_w)) begin
					brk_q <= 1'b0;
				end else if (brk_q && rd_rsr_w) begin
					back_q <= 1'b1;
				end
				if ((brk_end_q && brk_q && !back_q) || (late_w && !bon_q)) begin
					endp_q <= 1'b1;
				end else if (rd_rsr_w) begin
					endp_q <= 1'b0;
				end
			end
		end
	end

	assign ld_err_w = load_w & (wd_q.par_bad | (cfg_q.async_fmt & wd_q.frm_bad));
	assign err_evt  = ld_err_w | (rd_dat_w & ovp_q) | imm_w | late_w | end_irq_w | found_q;
	assign full_evt = load_w & ~ld_err_w;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			irq_err_o  <= 1'b0;
			irq_full_o <= 1'b0;
		end else if (ce_i) begin
			// Events of one cycle merge so a word raises a single request
			irq_err_o  <= err_evt & cfg_q.err_en & ~rx_off;
			irq_full_o <= (err_evt ? ~cfg_q.err_en : full_evt) & ~rx_off;
		end
	end

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence rd_ovr_s;
		ce_i && rd_dat_w && ovp_q && !rx_off;
	endsequence

	full_on_load_a:
	assert property (ce_i && load_w |=> bf_q && buf_q == $past(wd_q.data))
		else $error("buffer not loaded");
	keep_old_a:
	assert property (ce_i && ovr_w |=> $stable(buf_q))
		else $error("buffered word overwritten");
	oe_late_a:
	assert property (rd_ovr_s |=> oe_q ##0 (irq_err_o || irq_full_o))
		else $error("overrun not shown after read");
	oe_block_a:
	assert property (oe_q |-> !load_w)
		else $error("load while overrun set");
	oe_clear_a:
	assert property (ce_i && rd_rsr_w |=> !oe_q)
		else $error("overrun not cleared by status read");
	pe_track_a:
	assert property (ce_i && load_w |=> pe_q == $past(wd_q.par_bad))
		else $error("parity flag mismatch");
	strip_a:
	assert property (strip_w |-> !load_w ##1 !irq_full_o)
		else $error("sync word not stripped");
	found_irq_a:
	assert property (ce_i && found_q && cfg_q.err_en && !rx_off |=> irq_err_o && fs_q)
		else $error("sync found not signalled");
	one_irq_a:
	assert property (!(irq_full_o && irq_err_o))
		else $error("two requests at once");
	frozen_a:
	assert property (ce_i && !load_w && !rx_off |=> $stable(pe_q) && $stable(fe_q) && $stable(mt_q))
		else $error("flags changed without a load");
	re_off_a:
	assert property (ce_i && wr_rsr_w && !pwdata_i[`URSR_B_RE] |=> !bf_q && !oe_q && !fs_q && !brk_q)
		else $error("disable did not clear flags");
endmodule
`default_nettype wire

// File: test/ursr_line_model.sv
// Purpose: Remote transmitter driving the receive clock and serial line
// Assumes: Receive clock runs free at a quarter of ref_clk_i
// Notes:   Line idles at mark; bits change only while the receive clock is low
`timescale 1ns/100ps
`default_nettype none
module ursr_line_model (
	input  wire logic ref_clk_i,
	output logic      rx_clk_o,
	output logic      rx_data_o
);
	logic [1:0] cnt_q;

	initial begin
		cnt_q = 2'h0;
		rx_data_o = 1'b1;
	end

	// Clock runs before and after enable
	always @(posedge ref_clk_i) begin
		cnt_q <= cnt_q + 2'h1;
	end
	assign rx_clk_o = cnt_q[1];

	// Edge where the receive clock falls, so bits settle before it rises
	task automatic align;
		do @(posedge ref_clk_i); while (cnt_q !== 2'h3);
	endtask

	task automatic put(input logic v, input int n);
		rx_data_o <= v;
		repeat (4 * n) @(posedge ref_clk_i);
	endtask

	// Start bit, data LSB first, optional parity, stop
	task automatic send(input logic [7:0] d, input int div, input logic pon, input logic par,
			input logic stop);
		align();
		put(1'b0, div);
		for (int i = 0; i < 8; i++) put(d[i], div);
		if (pon) put(par, div);
		put(stop, div);
		put(1'b1, 2 * div);
	endtask

	// Synchronous bits with no framing; caller aligns once
	task automatic sync_bits(input logic [7:0] d);
		for (int i = 0; i < 8; i++) put(d[i], 1);
	endtask
endmodule
`default_nettype wire

// File: test/tb.sv
// Purpose: Self-checking bench for the receiver status block over APB
// Assumes: Zero wait state slave; interrupt pulses counted as they occur
// Notes:   Line rests low after the sync test word; bench stops the receiver
`timescale 1ns/100ps
`default_nettype none
`include "ursr_cfg.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
	logic        ref_clk_i;
	logic        rst_n_i;
	logic        psel, penable, pwrite, pready, pslverr;
	logic [9:0]  paddr;
	logic [31:0] pwdata, prdata, d;
	logic        rx_clk, rx_data, irq_full, irq_err, tx_wstb, e;
	logic [7:0]  tx_wdata;
	int          fails, n_compared, nf, ne, ntx, cyc;

	ursr_receiver uut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .rx_clk_i(rx_clk),
		.rx_data_i(rx_data), .irq_full_o(irq_full), .irq_err_o(irq_err),
		.tx_wdata_o(tx_wdata), .tx_wstb_o(tx_wstb));
	ursr_line_model model (.ref_clk_i(ref_clk_i), .rx_clk_o(rx_clk), .rx_data_o(rx_data));

	always #2.5 ref_clk_i = ~ref_clk_i;

	task automatic test_done;
		$display("compared=%0d fails=%0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	always @(posedge ref_clk_i) begin
		cyc++;
		if (irq_full === 1'b1) nf++;
		if (irq_err === 1'b1) ne++;
		if (tx_wstb === 1'b1) ntx++;
		if (irq_full === 1'b1) `CHK(irq_err, 1'b0)
		if (cyc == 40000) begin
			fails++;
			test_done();
		end
	end

	task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd,
			output logic [31:0] rd, output logic er);
		int k;
		@(posedge ref_clk_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge ref_clk_i);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge ref_clk_i);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k == 50) fails++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
		logic [31:0] r;
		logic        x;
		apb(1'b0, idx, 32'h0, r, x);
		`CHK(r, exp)
	endtask

	task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
		logic [31:0] r;
		logic        x;
		apb(1'b1, idx, wd, r, x);
	endtask

	// Bounded wait for interrupt totals, then a few settling cycles
	task automatic waitn(input int f, input int g);
		int k;
		k = 0;
		while ((nf < f || ne < g) && k < 3000) begin
			@(posedge ref_clk_i);
			k++;
		end
		repeat (4) @(posedge ref_clk_i);
	endtask

	initial begin
		ref_clk_i = 1'b0;
		rst_n_i = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (12) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		rdc(`URSR_IDX_RSR, 32'h00);
		rdc(`URSR_IDX_CFG, 32'h01);
		apb(1'b0, 8'h00, 32'h0, d, e);
		`CHK(e, 1'b1)
		wr(`URSR_IDX_DATA, 32'h3c);
		repeat (3) @(posedge ref_clk_i);
		`CHK(tx_wdata, 8'h3c)
		`CHK(ntx, 1)
		wr(`URSR_IDX_RSR, 32'h01);
		model.send(8'ha5, 1, 1'b0, 1'b0, 1'b1);
		waitn(1, 0);
		rdc(`URSR_IDX_RSR, 32'h81);
		rdc(`URSR_IDX_DATA, 32'ha5);
		rdc(`URSR_IDX_RSR, 32'h01);
		// Second word arrives while the first is unread
		model.send(8'h11, 1, 1'b0, 1'b0, 1'b1);
		model.send(8'h22, 1, 1'b0, 1'b0, 1'b1);
		waitn(2, 0);
		rdc(`URSR_IDX_RSR, 32'h81);
		rdc(`URSR_IDX_DATA, 32'h11);
		rdc(`URSR_IDX_RSR, 32'h41);
		rdc(`URSR_IDX_RSR, 32'h01);
		waitn(3, 0);
		`CHK(nf, 3)
		model.send(8'h33, 1, 1'b0, 1'b0, 1'b1);
		waitn(4, 0);
		rdc(`URSR_IDX_DATA, 32'h33);
		// Odd parity, error channel on
		wr(`URSR_IDX_CFG, 32'h15);
		model.send(8'h01, 1, 1'b1, 1'b1, 1'b1);
		waitn(4, 1);
		`CHK(nf, 4)
		rdc(`URSR_IDX_RSR, 32'ha1);
		rdc(`URSR_IDX_DATA, 32'h01);
		model.send(8'h03, 1, 1'b1, 1'b1, 1'b1);
		waitn(5, 1);
		rdc(`URSR_IDX_RSR, 32'h81);
		rdc(`URSR_IDX_DATA, 32'h03);
		wr(`URSR_IDX_CFG, 32'h1d);
		model.send(8'h01, 1, 1'b1, 1'b1, 1'b1);
		waitn(6, 1);
		rdc(`URSR_IDX_RSR, 32'h81);
		rdc(`URSR_IDX_DATA, 32'h01);
		// Missing stop bit on a nonzero word
		wr(`URSR_IDX_CFG, 32'h11);
		model.send(8'h40, 1, 1'b0, 1'b0, 1'b0);
		waitn(6, 2);
		rdc(`URSR_IDX_RSR, 32'h91);
		wr(`URSR_IDX_RSR, 32'h00);
		rdc(`URSR_IDX_RSR, 32'h00);
		// Break: zero word, no stop; end interrupt waits for the status read
		wr(`URSR_IDX_RSR, 32'h01);
		model.send(8'h00, 1, 1'b0, 1'b0, 1'b0);
		waitn(6, 3);
		`CHK(ne, 3)
		rdc(`URSR_IDX_RSR, 32'h09);
		waitn(6, 4);
		`CHK(ne, 4)
		rdc(`URSR_IDX_RSR, 32'h01);
		// Short low pulse must not start a word in divide-by-16
		wr(`URSR_IDX_CFG, 32'h03);
		wr(`URSR_IDX_RSR, 32'h01);
		model.align();
		model.put(1'b0, 4);
		model.put(1'b1, 40);
		model.send(8'h96, 16, 1'b0, 1'b0, 1'b1);
		waitn(7, 4);
		`CHK(nf, 7)
		rdc(`URSR_IDX_DATA, 32'h96);
		// Sync search with strip; zero words follow, so stop afterwards
		wr(`URSR_IDX_RSR, 32'h00);
		wr(`URSR_IDX_CFG, 32'h10);
		wr(`URSR_IDX_SCR, 32'h7e);
		wr(`URSR_IDX_RSR, 32'h03);
		model.align();
		model.sync_bits(8'h7e);
		model.sync_bits(8'h7e);
		model.sync_bits(8'h5a);
		waitn(8, 5);
		`CHK(ne, 5)
		`CHK(nf, 8)
		rdc(`URSR_IDX_RSR, 32'h8b);
		rdc(`URSR_IDX_DATA, 32'h5a);
		wr(`URSR_IDX_RSR, 32'h00);
		rdc(`URSR_IDX_RSR, 32'h00);
		test_done();
	end
endmodule
`default_nettype wire
